// File: core/cfg_sysref_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CFG_SYSREF_REGS_SVH
`define CFG_SYSREF_REGS_SVH
`define OFS_CONFIG_A 15'h0000
`define OFS_MAKER_ID_LO 15'h000c
`define OFS_MAKER_ID_HI 15'h000d
`define OFS_USER_SPI_CONFIG 15'h0010
`define OFS_CLOCK_CONTROL_ZERO 15'h0029
`define OFS_EDGE_POS_0 15'h002c
`define OFS_EDGE_POS_1 15'h002d
`define OFS_EDGE_POS_2 15'h002e
`define RST_CONFIG_A 8'h30
`define RST_USER_SPI_CONFIG 8'h00
`define RST_CLOCK_CONTROL_ZERO 8'h80
`define BIT_ASCEND 5
`define BIT_SDO_ACTIVE 4
`define BIT_ADDR_HOLD 0
`define BIT_PROC_EN 6
`define BIT_RECV_EN 5
`define BIT_ZOOM 4
`define MSB_DELAY 3
`define SPI_HALF_CYCLES 8'h04
`endif

// File: core/cfg_sysref_pkg.sv
// types used by the spi register device
package cfg_sysref_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [14:0] addr_t;
	typedef enum logic {OP_WRITE, OP_READ} op_t;
endpackage : cfg_sysref_pkg

// File: core/spi_link_if.sv
// four-wire spi link between host and register device
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	modport host (output sclk, output cs_n, output sdi, input sdo);
	modport device (input sclk, input cs_n, input sdi, output sdo);
endinterface : spi_link_if
`default_nettype wire

// File: core/spi_cfg_sysref_dev.sv
// spi register device: identification, user spi config and first clock control
// Contract
// - fixed 16-bit maker code, read only
// - address hold freezes streaming address
// - hold clear: step by direction bit
// - direction 0 decrements, 1 increments
// - processor enable gates sysref events
// - bit 5 enables sysref receiver
// - host enables receiver before processor
// - zoom selects finer window delays
// - zoom at high rates, multiple windows
// - 4-bit delay choice from position status
// - 24-bit edge position, read only
// - host writes reserved bits at defaults
// - reset values 0x80 and 0x00
`timescale 1ns/100ps
`default_nettype none
`include "cfg_sysref_regs.svh"
module spi_cfg_sysref_dev #(
	parameter logic [15:0] MAKER_CODE = 16'h5a5a // arbitrary value
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	spi_link_if.device LINK,
	input wire logic SYSREF_EVENT,
	input wire logic [23:0] EDGE_POSITION,
	output logic SYSREF_RECEIVER_ENABLE,
	output logic SYSREF_PROCESSOR_ENABLE,
	output logic SYSREF_FINE_WINDOW_SCALE,
	output logic [3:0] SYSREF_DELAY_CHOICE,
	output logic SYSREF_EVENT_TAKEN
);
	typedef enum logic [1:0] {ST_IDLE, ST_HEADER, ST_DATA} phase_t;
	phase_t phase_r;
	logic sclk_d_r;
	logic [4:0] cnt_r;
	logic [15:0] sh_r;
	logic [7:0] out_r;
	cfg_sysref_pkg::op_t op_r;
	cfg_sysref_pkg::addr_t addr_r;
	cfg_sysref_pkg::byte_t config_a_r;
	cfg_sysref_pkg::byte_t user_spi_config_r;
	cfg_sysref_pkg::byte_t clock_control_zero_r;
	logic [23:0] pos_r;
	logic sdo_r;
	wire rise = LINK.sclk & ~sclk_d_r & ~LINK.cs_n;
	wire fall = ~LINK.sclk & sclk_d_r & ~LINK.cs_n;
	wire [15:0] sh_nxt = {sh_r[14:0], LINK.sdi};

	function automatic cfg_sysref_pkg::byte_t read_reg(input cfg_sysref_pkg::addr_t a);
		unique case (a)
			`OFS_CONFIG_A: read_reg = config_a_r | 8'h10;
			`OFS_MAKER_ID_LO: read_reg = MAKER_CODE[7:0];
			`OFS_MAKER_ID_HI: read_reg = MAKER_CODE[15:8];
			`OFS_USER_SPI_CONFIG: read_reg = user_spi_config_r;
			`OFS_CLOCK_CONTROL_ZERO: read_reg = clock_control_zero_r;
			`OFS_EDGE_POS_0: read_reg = pos_r[7:0];
			`OFS_EDGE_POS_1: read_reg = pos_r[15:8];
			`OFS_EDGE_POS_2: read_reg = pos_r[23:16];
			default: read_reg = 8'h00;
		endcase
	endfunction : read_reg

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= LINK.sclk;
		end
	end

	// frame: 16-bit header (r/w, 15-bit address) then data bytes
	always_ff @(posedge SYS_CLK) begin
		if (RST || LINK.cs_n) begin
			phase_r <= ST_IDLE;
			cnt_r <= 5'h00;
			sh_r <= 16'h0000;
			op_r <= cfg_sysref_pkg::OP_WRITE;
			addr_r <= 15'h0000;
			out_r <= 8'h00;
		end else if (rise) begin
			sh_r <= sh_nxt;
			if (phase_r != ST_DATA && cnt_r == 5'h0f) begin
				phase_r <= ST_DATA;
				cnt_r <= 5'h00;
				op_r <= sh_nxt[15] ? cfg_sysref_pkg::OP_READ : cfg_sysref_pkg::OP_WRITE;
				addr_r <= sh_nxt[14:0];
				out_r <= read_reg(sh_nxt[14:0]);
			end else if (phase_r == ST_DATA && cnt_r == 5'h07) begin
				cnt_r <= 5'h00;
				if (user_spi_config_r[`BIT_ADDR_HOLD]) begin
					out_r <= read_reg(addr_r);
				end else if (config_a_r[`BIT_ASCEND]) begin
					addr_r <= addr_r + 15'h0001;
					out_r <= read_reg(addr_r + 15'h0001);
				end else begin
					addr_r <= addr_r - 15'h0001;
					out_r <= read_reg(addr_r - 15'h0001);
				end
			end else if (phase_r == ST_DATA) begin
				cnt_r <= cnt_r + 5'h01;
			end else begin
				phase_r <= ST_HEADER;
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end

	wire wr_byte = rise && phase_r == ST_DATA && cnt_r == 5'h07 && op_r == cfg_sysref_pkg::OP_WRITE;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sdo_r <= 1'b0;
		end else if (LINK.cs_n) begin
			sdo_r <= 1'b0;
		end else if (fall && phase_r == ST_DATA && op_r == cfg_sysref_pkg::OP_READ) begin
			sdo_r <= out_r[3'h7 - cnt_r[2:0]];
		end
	end
	assign LINK.sdo = sdo_r;

	// soft reset bit not kept, sdo-active bit pinned high
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			config_a_r <= `RST_CONFIG_A;
		end else if (wr_byte && addr_r == `OFS_CONFIG_A) begin
			config_a_r <= {1'b0, sh_nxt[6:5], 1'b1, sh_nxt[3:0]};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			user_spi_config_r <= `RST_USER_SPI_CONFIG;
		end else if (wr_byte && addr_r == `OFS_USER_SPI_CONFIG) begin
			user_spi_config_r <= sh_nxt[7:0];
		end
	end

	// clock control resets with bit 7
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			clock_control_zero_r <= `RST_CLOCK_CONTROL_ZERO;
		end else if (wr_byte && addr_r == `OFS_CLOCK_CONTROL_ZERO) begin
			clock_control_zero_r <= sh_nxt[7:0];
		end
	end

	// status sampled only while deselected so a multi-byte read sees one steady value for the whole frame
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pos_r <= 24'h000000;
		end else if (LINK.cs_n) begin
			pos_r <= EDGE_POSITION;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SYSREF_RECEIVER_ENABLE <= 1'b0;
		end else begin
			SYSREF_RECEIVER_ENABLE <= clock_control_zero_r[`BIT_RECV_EN];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SYSREF_PROCESSOR_ENABLE <= 1'b0;
		end else begin
			SYSREF_PROCESSOR_ENABLE <= clock_control_zero_r[`BIT_PROC_EN];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SYSREF_FINE_WINDOW_SCALE <= 1'b0;
		end else begin
			SYSREF_FINE_WINDOW_SCALE <= clock_control_zero_r[`BIT_ZOOM];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SYSREF_DELAY_CHOICE <= 4'h0;
		end else begin
			SYSREF_DELAY_CHOICE <= clock_control_zero_r[`MSB_DELAY:0];
		end
	end

	// events ignored unless processor on
	// receiver gate too: an event before the receiver is up is noise
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SYSREF_EVENT_TAKEN <= 1'b0;
		end else begin
			SYSREF_EVENT_TAKEN <= SYSREF_EVENT & clock_control_zero_r[`BIT_PROC_EN]
				& clock_control_zero_r[`BIT_RECV_EN];
		end
	end
endmodule : spi_cfg_sysref_dev
`default_nettype wire

// File: core/spi_cfg_sysref_host.sv
// spi host that runs one- or two-byte register writes and reads
`timescale 1ns/100ps
`default_nettype none
`include "cfg_sysref_regs.svh"
module spi_cfg_sysref_host (
	input wire logic SYS_CLK,
	input wire logic RST,
	spi_link_if.host LINK,
	input wire logic [1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA
);
	// regs: 0 command {two[25], op[24], addr[22:8], data[7:0]} write starts; 1 status {busy}; 2 read byte
	// two-byte frames repeat the data byte; the read byte is the last one shifted in
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_END} state_t;
	state_t state_r;
	logic [31:0] sh_r;
	logic long_r;
	logic [4:0] bits_r;
	logic [7:0] div_r;
	logic [7:0] rx_r;
	logic sclk_r, cs_n_r, sdi_r;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_r <= ST_IDLE;
			sh_r <= 32'h00000000;
			long_r <= 1'b0;
			bits_r <= 5'h00;
			div_r <= 8'h00;
			rx_r <= 8'h00;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			sdi_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (WR && ADDR == 2'h0) begin
						// reserved bits left to software, passed through as written
						sh_r <= {WDATA[24], WDATA[22:8], WDATA[7:0], WDATA[7:0]};
						long_r <= WDATA[25];
						sdi_r <= WDATA[24];
						cs_n_r <= 1'b0;
						bits_r <= 5'h00;
						div_r <= 8'h00;
						state_r <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (div_r == `SPI_HALF_CYCLES - 8'h01) begin
						div_r <= 8'h00;
						sclk_r <= ~sclk_r;
						if (!sclk_r) begin
							rx_r <= {rx_r[6:0], LINK.sdo};
						end else begin
							sh_r <= {sh_r[30:0], 1'b0};
							sdi_r <= sh_r[30];
							bits_r <= bits_r + 5'h01;
							if (bits_r == (long_r ? 5'h1f : 5'h17)) begin
								state_r <= ST_END;
							end
						end
					end else begin
						div_r <= div_r + 8'h01;
					end
				end
				ST_END: begin
					cs_n_r <= 1'b1;
					state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
	assign LINK.sclk = sclk_r;
	assign LINK.cs_n = cs_n_r;
	assign LINK.sdi = sdi_r;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RDATA <= 32'h00000000;
		end else if (RD) begin
			unique case (ADDR)
				2'h1: RDATA <= {31'h0, state_r != ST_IDLE};
				2'h2: RDATA <= {24'h0, rx_r};
				default: RDATA <= 32'h00000000;
			endcase
		end else begin
			RDATA <= 32'h00000000;
		end
	end
endmodule : spi_cfg_sysref_host
`default_nettype wire

// File: testbench/spi_link_asserts.sv
// wire-level checks on the spi link between host and device
`timescale 1ns/100ps
`default_nettype none
module spi_link_asserts (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo
);
	logic [5:0] rises_r;
	logic sclk_q_r;
	logic [8:0] len_r;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// counts rising edges and cycles inside a frame, cleared between frames
	always_ff @(posedge SYS_CLK) begin
		sclk_q_r <= sclk;
		if (RST || cs_n)
			rises_r <= 6'h00;
		else if (sclk && !sclk_q_r)
			rises_r <= rises_r + 6'h01;
		if (RST || cs_n)
			len_r <= 9'h000;
		else
			len_r <= len_r + 9'h001;
	end
	a_idle_clock_low: assert property (cs_n |-> !sclk) else $error("sclk high while deselected");
	a_reset_deselects: assert property (disable iff (1'b0) RST |=> cs_n && !sclk) else $error("reset left link active");
	a_high_phase: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("sclk high phase wrong");
	a_low_phase: assert property ($fell(sclk) |-> !sclk[*4]) else $error("sclk low phase short");
	a_sdi_steady: assert property (sclk |-> $stable(sdi)) else $error("sdi moved while sclk high");
	a_sdo_steady: assert property (sclk |-> $stable(sdo)) else $error("sdo moved while sclk high");
	a_rise_count: assert property ($rose(cs_n) |-> rises_r == 6'd24 || rises_r == 6'd32) else $error("frame not 24 or 32 bits");
	a_frame_length: assert property ($rose(cs_n) |-> (rises_r == 6'd24 && len_r == 9'd193) || (rises_r == 6'd32 && len_r == 9'd257)) else $error("frame length wrong");
	cover property ($fell(cs_n));
	cover property (rises_r == 6'd24);
	cover property ($rose(sdo));
	cover property ($rose(cs_n) && rises_r == 6'd32);
endmodule : spi_link_asserts
`default_nettype wire

// File: testbench/spi_cfg_and_sysref_ctrl_regs_test.sv
// self-checking bench joining the spi host and the register device
`timescale 1ns/100ps
`default_nettype none
`include "cfg_sysref_regs.svh"
module spi_cfg_and_sysref_ctrl_regs_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ev = 1'b0;
	logic [23:0] pos = 24'h0;
	logic [31:0] rdata;
	logic recv_en, proc_en, zoom, taken, rd_seen;
	logic [3:0] delay;
	logic [7:0] v;
	logic [23:0] pv;
	logic [7:0] expq[$];
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	spi_link_if link ();
	spi_cfg_sysref_host i_spi_cfg_sysref_host (.SYS_CLK(clk), .RST(rst), .LINK(link), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
	// maker code is arbitrary
	spi_cfg_sysref_dev #(.MAKER_CODE(16'h3c96)) i_spi_cfg_sysref_dev (.SYS_CLK(clk), .RST(rst), .LINK(link),
		.SYSREF_EVENT(ev), .EDGE_POSITION(pos), .SYSREF_RECEIVER_ENABLE(recv_en),
		.SYSREF_PROCESSOR_ENABLE(proc_en), .SYSREF_FINE_WINDOW_SCALE(zoom),
		.SYSREF_DELAY_CHOICE(delay), .SYSREF_EVENT_TAKEN(taken));
	spi_link_asserts i_spi_link_asserts (.SYS_CLK(clk), .RST(rst), .sclk(link.sclk), .cs_n(link.cs_n),
		.sdi(link.sdi), .sdo(link.sdo));
	always #2 clk = ~clk;
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	// one frame, then status polled back to back until idle
	task automatic spi(input logic op, input logic [14:0] a, input logic [7:0] d, input logic two = 1'b0);
		int n;
		@(posedge clk);
		wr <= 1'b1;
		wdata <= {6'h00, two, op, 1'b0, a, d};
		@(posedge clk);
		wr <= 1'b0;
		addr <= 2'h1;
		rd <= 1'b1;
		n = 0;
		// a hang is caught by the cycle ceiling
		do begin
			@(posedge clk);
			n++;
		end while (rdata[0] !== 1'b0 || n < 3);
		rd <= 1'b0;
		addr <= 2'h0;
	endtask : spi
	task automatic rdreg(input logic [14:0] a, input logic [7:0] exp, input logic two = 1'b0);
		spi(1'b1, a, 8'h00, two);
		// one idle cycle so rd and addr are not driven twice in one step
		@(posedge clk);
		expq.push_back(exp);
		addr <= 2'h2;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= 2'h0;
	endtask : rdreg
	task automatic pulse(input logic exp);
		@(posedge clk);
		ev <= 1'b1;
		@(posedge clk);
		ev <= 1'b0;
		#1 check("event taken", 32'(taken), 32'(exp));
	endtask : pulse
	// read byte lands one cycle after its strobe
	always @(posedge clk) begin
		rd_seen <= rd && addr == 2'h2;
		if (rd_seen === 1'b1 && expq.size() > 0)
			check("read byte", 32'(rdata[7:0]), 32'(expq.pop_front()));
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		void'($urandom(23));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdreg(`OFS_CLOCK_CONTROL_ZERO, `RST_CLOCK_CONTROL_ZERO);
		rdreg(`OFS_USER_SPI_CONFIG, `RST_USER_SPI_CONFIG);
		check("outputs", 32'({proc_en, recv_en, zoom, delay}), 32'h0);
		spi(1'b0, `OFS_MAKER_ID_LO, 8'hff);
		rdreg(`OFS_MAKER_ID_LO, 8'h96);
		rdreg(`OFS_MAKER_ID_HI, 8'h3c);
		pulse(1'b0);
		v = 8'($urandom);
		// receiver before processor, bit 7 kept set
		spi(1'b0, `OFS_CLOCK_CONTROL_ZERO, {3'h5, v[4:0]});
		pulse(1'b0);
		spi(1'b0, `OFS_CLOCK_CONTROL_ZERO, {3'h7, v[4:0]});
		check("outputs", 32'({proc_en, recv_en, zoom, delay}), 32'({2'h3, v[4:0]}));
		rdreg(`OFS_CLOCK_CONTROL_ZERO, {3'h7, v[4:0]});
		pulse(1'b1);
		pv = 24'($urandom);
		@(posedge clk);
		pos <= pv;
		rdreg(`OFS_EDGE_POS_0, pv[7:0]);
		rdreg(`OFS_EDGE_POS_1, pv[15:8]);
		rdreg(`OFS_EDGE_POS_2, pv[23:16]);
		// two-byte reads: the second byte shows where the address went
		rdreg(`OFS_MAKER_ID_LO, 8'h3c, 1'b1);
		spi(1'b0, `OFS_CONFIG_A, 8'h00);
		rdreg(`OFS_CONFIG_A, 8'h10);
		rdreg(`OFS_MAKER_ID_HI, 8'h96, 1'b1);
		spi(1'b0, `OFS_USER_SPI_CONFIG, 8'h01);
		rdreg(`OFS_USER_SPI_CONFIG, 8'h01);
		rdreg(`OFS_MAKER_ID_LO, 8'h96, 1'b1);
		// unmapped place drops writes
		spi(1'b0, 15'h007f, 8'ha5);
		rdreg(15'h007f, 8'h00);
		repeat (4) @(posedge clk);
		check("pending reads", 32'(expq.size()), 32'h0);
		close_out();
	end
endmodule : spi_cfg_and_sysref_ctrl_regs_test
`default_nettype wire
